// ===== core/fsbc_pkg.sv
// Purpose: constants for the flash security bit control block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   offsets are byte addresses within the block
package fsbc_pkg;
	localparam logic [7:0]  SEC_REG_OFS      = 8'h00;
	localparam logic [7:0]  FLASH_STAT_OFS   = 8'h20;
	localparam logic [7:0]  PROT_CMD_OFS     = 8'h40;
	localparam logic [7:0]  MODE_OFS         = 8'h44;
	localparam int          SEC_BIT_POS      = 0;
	localparam logic [31:0] SEC_RESET_VAL    = 32'h0000_0001;
	localparam logic [31:0] UNLOCK_KEY       = 32'hA74A_9D23;
	localparam int          KEY_WINDOW_CLK   = 16;
	localparam logic [4:0]  KEY_WINDOW_CNT   = 5'(KEY_WINDOW_CLK);
	localparam int          BLK_NUM          = 6;
	localparam int          PROT_LSB         = 16;
	localparam int          READY_POS        = 0;
	localparam logic [5:0]  GROUP_LOW_MASK   = 6'h0F;
	localparam logic [5:0]  GROUP_HIGH_MASK  = 6'h30;
	localparam logic [1:0]  CMD_NONE         = 2'h0;
	localparam logic [1:0]  CMD_PROGRAM      = 2'h1;
	localparam logic [1:0]  CMD_ERASE        = 2'h2;
	localparam int          CMD_LSB          = 8;
	localparam int          GROUP_POS        = 4;
	localparam logic [1:0]  MODE_SINGLE_CHIP = 2'h0;
	localparam logic [1:0]  MODE_SINGLE_BOOT = 2'h1;
	localparam logic [1:0]  MODE_PROGRAMMER  = 2'h2;
	localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
endpackage

// ===== core/fsbc_top.sv
// Purpose: flash security-enable bit and protection-bit command gate
// Assumes: one 50 MHz clock; por_n is the power-on reset, rstn any reset
// Notes:   protection bits themselves live in the sequencer, seen on prot_flags
//          register map, byte offsets:
//          0x00 security_enable_register, bit 0 security_enable
//          0x20 flash_control_status, 21:16 block_protect_flags, 0 sequencer ready
//          0x40 protection command: 9:8 command, 2:0 block, 4 erase group;
//               reads back the last command's erase flag at 9 and mask at 5:0
//          0x44 operating mode, 1:0: chip, boot, programmer; the spare code
//               blocks protection commands
//          key and data writes need all four byte enables
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module fsbc_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        por_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [5:0]  prot_flags,
	input  wire logic        seq_ready,
	input  wire logic        flash_cmd_req,
	output logic             flash_cmd_ok,
	output logic             prot_cmd_valid,
	output logic             prot_cmd_erase,
	output logic      [5:0]  prot_cmd_mask,
	output logic             security_active,
	output logic             debug_block
);
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        req;
	logic        wr_fire;
	logic        full_word;
	logic        sec_hit;
	logic        unlock_reg;
	logic [4:0]  win_cnt_reg;
	logic        security_enable_reg;
	logic [1:0]  mode_reg;
	logic [5:0]  one_hot;
	logic [2:0]  blk_sel;
	logic [1:0]  cmd_code;
	logic        all_prot;
	logic        mode_ok;
	logic        key_match;
	logic        key_take;
	logic        data_take;
	logic        win_last;
	logic        mode_wr;
	logic [31:0] rd_next;
	logic        cmd_hit;
	logic        cmd_take;
	logic        blk_ok;
	logic        grp_high;
	logic        prog_go;
	logic        erase_go;
	logic [5:0]  erase_mask;
	logic        valid_next;
	logic        erase_next;
	logic [5:0]  mask_next;

	assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_fire   = req & wb_we_i;
	assign full_word = (wb_sel_i == 4'hF);
	assign sec_hit   = wr_fire & (wb_adr_i == fsbc_pkg::SEC_REG_OFS);
	assign all_prot  = &prot_flags;
	assign cmd_code  = wb_dat_i[fsbc_pkg::CMD_LSB +: 2];
	assign blk_sel   = wb_dat_i[2:0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// unmapped offsets read as zero
	always_comb begin
		case (wb_adr_i)
			fsbc_pkg::SEC_REG_OFS: begin
				rd_next = {31'h0000_0000, security_enable_reg};
			end
			fsbc_pkg::FLASH_STAT_OFS: begin
				rd_next = {10'h000, prot_flags, 15'h0000, seq_ready};
			end
			fsbc_pkg::PROT_CMD_OFS: begin
				rd_next = {22'h00_0000, prot_cmd_erase, 3'h0, prot_cmd_mask};
			end
			fsbc_pkg::MODE_OFS: begin
				rd_next = {30'h0000_0000, mode_reg};
			end
			default: begin
				rd_next = fsbc_pkg::UNMAPPED_DATA;
			end
		endcase
	end

	// read data holds until the next read
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_dat_o <= fsbc_pkg::UNMAPPED_DATA;
		end else if (req & ~wb_we_i) begin
			wb_dat_o <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// key window
	// ----------------------------------------------------------------
	assign key_match = full_word & (wb_dat_i == fsbc_pkg::UNLOCK_KEY);
	assign key_take  = sec_hit & ~unlock_reg & key_match;
	assign data_take = sec_hit & unlock_reg & full_word;
	assign win_last  = unlock_reg & (win_cnt_reg == 5'h01);

	// any other write to the register while unlocked closes the window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			unlock_reg <= 1'b0;
		end else if (key_take) begin
			unlock_reg <= 1'b1;
		end else if (sec_hit) begin
			unlock_reg <= 1'b0;
		end else if (win_last) begin
			unlock_reg <= 1'b0;
		end
	end

	// clocks left in the window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			win_cnt_reg <= 5'h00;
		end else if (key_take) begin
			win_cnt_reg <= fsbc_pkg::KEY_WINDOW_CNT;
		end else if (sec_hit) begin
			win_cnt_reg <= 5'h00;
		end else if (unlock_reg) begin
			win_cnt_reg <= win_cnt_reg - 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// security bit
	// ----------------------------------------------------------------
	// power-on reset only; the system reset leaves it alone
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			security_enable_reg <= fsbc_pkg::SEC_RESET_VAL[fsbc_pkg::SEC_BIT_POS];
		end else if (data_take) begin
			security_enable_reg <= wb_dat_i[fsbc_pkg::SEC_BIT_POS];
		end
	end

	// ----------------------------------------------------------------
	// operating mode
	// ----------------------------------------------------------------
	assign mode_wr = wr_fire & (wb_adr_i == fsbc_pkg::MODE_OFS);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= fsbc_pkg::MODE_SINGLE_CHIP;
		end else if (mode_wr) begin
			mode_reg <= wb_dat_i[1:0];
		end
	end

	// the spare mode code blocks protection commands
	always_comb begin
		case (mode_reg)
			fsbc_pkg::MODE_SINGLE_CHIP: begin
				mode_ok = 1'b1;
			end
			fsbc_pkg::MODE_SINGLE_BOOT: begin
				mode_ok = 1'b1;
			end
			fsbc_pkg::MODE_PROGRAMMER: begin
				mode_ok = 1'b1;
			end
			default: begin
				mode_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// security status
	// ----------------------------------------------------------------
	assign security_active = security_enable_reg & all_prot;
	assign debug_block     = security_active;
	assign flash_cmd_ok    = flash_cmd_req & ~security_active;

	// ----------------------------------------------------------------
	// protection-bit commands toward the sequencer
	// ----------------------------------------------------------------
	assign cmd_hit  = wr_fire & (wb_adr_i == fsbc_pkg::PROT_CMD_OFS);
	assign cmd_take = cmd_hit & mode_ok & seq_ready;
	assign blk_ok   = (one_hot != 6'h00);
	assign grp_high = wb_dat_i[fsbc_pkg::GROUP_POS];
	assign prog_go  = cmd_take & (cmd_code == fsbc_pkg::CMD_PROGRAM) & blk_ok;
	assign erase_go = cmd_take & (cmd_code == fsbc_pkg::CMD_ERASE);

	// one block per program command; indexes past the last block give none
	always_comb begin
		one_hot = 6'h00;
		if (blk_sel < 3'(fsbc_pkg::BLK_NUM)) begin
			one_hot[blk_sel] = 1'b1;
		end
	end

	// erase by group, or every block while security is active
	always_comb begin
		if (security_active) begin
			erase_mask = fsbc_pkg::GROUP_LOW_MASK | fsbc_pkg::GROUP_HIGH_MASK;
		end else if (grp_high) begin
			erase_mask = fsbc_pkg::GROUP_HIGH_MASK;
		end else begin
			erase_mask = fsbc_pkg::GROUP_LOW_MASK;
		end
	end

	// erase flag and mask hold until the next accepted command
	always_comb begin
		valid_next = 1'b0;
		erase_next = prot_cmd_erase;
		mask_next  = prot_cmd_mask;
		if (prog_go) begin
			valid_next = 1'b1;
			erase_next = 1'b0;
			mask_next  = one_hot;
		end else if (erase_go) begin
			valid_next = 1'b1;
			erase_next = 1'b1;
			mask_next  = erase_mask;
		end
	end

	// one-clock command strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prot_cmd_valid <= 1'b0;
		end else begin
			prot_cmd_valid <= valid_next;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prot_cmd_erase <= 1'b0;
		end else begin
			prot_cmd_erase <= erase_next;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prot_cmd_mask <= 6'h00;
		end else begin
			prot_cmd_mask <= mask_next;
		end
	end
endmodule

// ===== test/fsbc_asserts.sv
// Purpose: port checks for fsbc_top
// Assumes: rstn low clears every output but security_active, debug_block and flash_cmd_ok
// Notes:   bound from the bench
`timescale 1ns/1ps
module fsbc_asserts (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       flash_cmd_req,
	input wire logic       flash_cmd_ok,
	input wire logic       prot_cmd_valid,
	input wire logic       prot_cmd_erase,
	input wire logic [5:0] prot_cmd_mask,
	input wire logic       security_active,
	input wire logic       debug_block
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	AST_ACK: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack");
	AST_CAUSE: assert property (wb_ack_o
		|-> $past(wb_cyc_i && wb_stb_i)) else $error("cause");
	AST_DBG: assert property (debug_block == security_active) else $error("dbg");
	AST_OK: assert property (flash_cmd_ok == (flash_cmd_req & ~security_active))
		else $error("ok");
	AST_PRG: assert property (prot_cmd_valid && !prot_cmd_erase
		|-> $onehot(prot_cmd_mask)) else $error("prg");
	AST_GRP: assert property (prot_cmd_valid && prot_cmd_erase && !$past(security_active)
		|-> prot_cmd_mask inside {6'h0F, 6'h30}) else $error("grp");
	AST_ALL: assert property (prot_cmd_valid && prot_cmd_erase && $past(security_active)
		|-> prot_cmd_mask == 6'h3F) else $error("all");
	AST_CAK: assert property (prot_cmd_valid |-> wb_ack_o) else $error("cak");
endmodule

// ===== test/flash_security_bit_control_tb.sv
// Purpose: bench for fsbc_top
// Assumes: por_n with rstn at start
// Notes:   classic wishbone tasks
`timescale 1ns/1ps
module flash_security_bit_control_tb;
	localparam logic [31:0] KEY = fsbc_pkg::UNLOCK_KEY;
	logic        clk = 0, rstn = 0, por_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic        seq_ready = 1, flash_cmd_req = 1, wb_ack_o, flash_cmd_ok, prot_cmd_valid;
	logic        prot_cmd_erase, security_active, debug_block, cv;
	logic [7:0]  wb_adr_i = 0;
	logic [3:0]  wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic [5:0]  prot_flags = 0, prot_cmd_mask, cm;
	int          mismatches = 0, checks_done = 0;
	fsbc_top dut (.*);
	always #10 clk = ~clk;
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hF, logic w = 1);
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		{rd, cv, cm} = {wb_dat_o, prot_cmd_valid, prot_cmd_mask};
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic sec(logic [31:0] e);
		bus(8'h0, 0, 4'hF, 0);
		chk("security_enable", e, rd);
	endtask
	task automatic rst(logic p, logic [31:0] e);
		@(posedge clk);
		{rstn, por_n} <= {1'b0, ~p};
		repeat (2) @(posedge clk);
		{rstn, por_n} <= 2'b11;
		sec(e);
	endtask
	task automatic summarize();
		$display("checks_done %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clk);
		{rstn, por_n} <= 2'b11;
		sec(1);
		chk("security_active", 0, security_active);
		bus(8'h4, 0, 4'hF, 0);
		chk("unmapped", 0, rd);
		bus(8'h0, KEY);
		bus(8'h0, 0);
		sec(0);
		bus(8'h0, KEY);
		bus(8'h0, 1, 4'h3);
		sec(0);
		bus(8'h0, 1);
		sec(0);
		bus(8'h0, KEY);
		repeat (17) @(posedge clk);
		bus(8'h0, 1);
		sec(0);
		bus(8'h0, KEY);
		repeat (13) @(posedge clk);
		bus(8'h0, 1);
		sec(1);
		rst(0, 1);
		rst(1, 1);
		prot_flags <= 6'h3F;
		bus(8'h40, 32'h200);
		chk("erase_all", 32'h7F, {25'b0, cv, cm});
		chk("security_active", 1, security_active);
		chk("debug_block", 1, debug_block);
		chk("flash_cmd_ok", 0, flash_cmd_ok);
		bus(8'h20, 0, 4'hF, 0);
		chk("flash_status", 32'h003F_0001, rd);
		bus(8'h0, KEY);
		bus(8'h0, 0);
		chk("debug_block", 0, debug_block);
		chk("flash_cmd_ok", 1, flash_cmd_ok);
		for (int g = 0; g < 2; g++) begin
			bus(8'h40, 32'h200 | (g << 4));
			chk("erase_grp", g ? 32'h70 : 32'h4F, {25'b0, cv, cm});
		end
		bus(8'h40, 0, 4'hF, 0);
		chk("last_cmd", 32'h0000_0230, rd);
		for (int m = 3; m >= 0; m--) begin
			bus(8'h44, m);
			bus(8'h40, 32'h100 | (m + 2));
			chk("program", m < 3 ? 32'h40 | (1 << (m + 2)) : 0, {25'b0, cv, cm & {6{cv}}});
		end
		seq_ready <= 0;
		bus(8'h40, 32'h100);
		chk("busy_refused", 0, {31'b0, cv});
		seq_ready <= 1;
		bus(8'h40, 32'h107);
		chk("block_refused", 0, {31'b0, cv});
		summarize();
	end
endmodule
bind fsbc_top fsbc_asserts u_chk (.*);
